/* verilog/plc_state_pkg.sv */
// Constants and types shared by the controller run/stop state logic.
// Assumes a single 100 MHz clock domain with an active-high asynchronous reset.
`default_nettype none

package plc_state_pkg;

  // ---------------------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------------------
  localparam int IO_WIDTH        = 8;
  localparam int RETAIN_WIDTH    = 16;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int COPY_TIME_NS    = 200;
  localparam int COPY_CYCLES     = (COPY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COPY_CNT_WIDTH  = 8;
  localparam int INIT_TIME_NS    = 1000;
  localparam int INIT_CYCLES     = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_CNT_WIDTH  = 8;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [IO_WIDTH-1:0]     OUTPUTS_RESET = 8'h00;
  localparam logic [RETAIN_WIDTH-1:0] RETAIN_RESET  = 16'h0000;

  // ---------------------------------------------------------------------------
  // Indicator colours
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    LED_OFF,
    LED_RED,
    LED_GREEN,
    LED_ORANGE
  } led_colour_t;

  // ---------------------------------------------------------------------------
  // Scan cycle phases
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCAN_IDLE,
    SCAN_SAMPLE,
    SCAN_EVAL,
    SCAN_DRIVE
  } scan_phase_t;

endpackage : plc_state_pkg

`default_nettype wire

/* verilog/scan_if.sv */
// Interface carrying scan strobes between the main state logic and the scan engine.
// Assumes both ends share clk_in.
`default_nettype none

interface scan_if;
  logic                                   run;
  logic                                   sample;
  logic                                   evaluate;
  logic                                   drive;
  logic [plc_state_pkg::IO_WIDTH-1:0]     inputs;
  logic [plc_state_pkg::IO_WIDTH-1:0]     result;
  logic [plc_state_pkg::IO_WIDTH-1:0]     outputs;

  modport ctrl (
    output run,
    input  sample,
    input  evaluate,
    input  drive,
    input  outputs
  );

  modport engine (
    input  run,
    output sample,
    output evaluate,
    output drive,
    input  inputs,
    input  result,
    output outputs
  );
endinterface : scan_if

`default_nettype wire

/* verilog/scan_engine.sv */
// Scan cycle engine: sample inputs, evaluate, drive outputs, only while running.
// Assumes the evaluation result is presented combinationally on result.
`default_nettype none

module scan_engine (
  input  wire logic clk_in,
  input  wire logic rst_in,
  scan_if.engine    scan
);

  plc_state_pkg::scan_phase_t phase;

  // ---------------------------------------------------------------------------
  // Phase sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase <= plc_state_pkg::SCAN_IDLE;
    end else if (!scan.run) begin
      phase <= plc_state_pkg::SCAN_IDLE;
    end else begin
      unique case (phase)
        plc_state_pkg::SCAN_IDLE:   phase <= plc_state_pkg::SCAN_SAMPLE;
        plc_state_pkg::SCAN_SAMPLE: phase <= plc_state_pkg::SCAN_EVAL;
        plc_state_pkg::SCAN_EVAL:   phase <= plc_state_pkg::SCAN_DRIVE;
        plc_state_pkg::SCAN_DRIVE:  phase <= plc_state_pkg::SCAN_SAMPLE;
      endcase
    end
  end

  assign scan.sample   = (phase == plc_state_pkg::SCAN_SAMPLE);
  assign scan.evaluate = (phase == plc_state_pkg::SCAN_EVAL);
  assign scan.drive    = (phase == plc_state_pkg::SCAN_DRIVE);

  // ---------------------------------------------------------------------------
  // Output image
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scan.outputs <= plc_state_pkg::OUTPUTS_RESET;
    end else if (!scan.run) begin
      scan.outputs <= plc_state_pkg::OUTPUTS_RESET;
    end else if (phase == plc_state_pkg::SCAN_DRIVE) begin
      scan.outputs <= scan.result;
    end
  end

endmodule : scan_engine

`default_nettype wire

/* verilog/expansion_led.sv */
// Expansion module link indicator: orange while initialising, then green or red.
// Assumes link_ok_in is synchronous to clk_in.
`default_nettype none

module expansion_led (
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       link_ok_in,
  output var  plc_state_pkg::led_colour_t colour_out
);

  logic [plc_state_pkg::INIT_CNT_WIDTH-1:0] init_count;
  logic                                     init_done;

  // ---------------------------------------------------------------------------
  // Initialisation timer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      init_count <= '0;
      init_done  <= 1'b0;
    end else if (!init_done) begin
      if (init_count == plc_state_pkg::INIT_CNT_WIDTH'(plc_state_pkg::INIT_CYCLES - 1)) begin
        init_done <= 1'b1;
      end
      init_count <= init_count + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Colour
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      colour_out <= plc_state_pkg::LED_ORANGE;
    end else if (!init_done) begin
      colour_out <= plc_state_pkg::LED_ORANGE;
    end else if (link_ok_in) begin
      colour_out <= plc_state_pkg::LED_GREEN;
    end else begin
      colour_out <= plc_state_pkg::LED_RED;
    end
  end

endmodule : expansion_led

`default_nettype wire

/* verilog/controller_run_stop_state.sv */
// Power-on and run/stop state logic of a small programmable controller.
// Assumes all inputs are synchronous to clk_in; the power-loss memory is outside.
`default_nettype none

module controller_run_stop_state #(
  parameter int IO_WIDTH     = plc_state_pkg::IO_WIDTH,
  parameter int RETAIN_WIDTH = plc_state_pkg::RETAIN_WIDTH
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       has_display_in,
  input  wire logic                       internal_prog_valid_in,
  input  wire logic                       card_present_in,
  input  wire logic                       card_prog_valid_in,
  input  wire logic                       saved_run_in,
  input  wire logic                       saved_editing_in,
  input  wire logic                       retain_enable_in,
  input  wire logic [RETAIN_WIDTH-1:0]    saved_retain_in,
  input  wire logic [RETAIN_WIDTH-1:0]    live_retain_in,
  input  wire logic                       power_fail_in,
  input  wire logic                       esc_in,
  input  wire logic                       start_req_in,
  input  wire logic                       stop_req_in,
  input  wire logic                       edit_req_in,
  input  wire logic                       edit_exit_in,
  input  wire logic                       param_req_in,
  input  wire logic                       param_exit_in,
  input  wire logic                       card_write_req_in,
  input  wire logic [IO_WIDTH-1:0]        inputs_in,
  input  wire logic [IO_WIDTH-1:0]        result_in,
  input  wire logic                       link_ok_in,
  output logic                            copy_card_out,
  output logic                            clear_prog_out,
  output logic                            card_write_out,
  output logic                            no_prog_msg_out,
  output logic                            running_out,
  output logic                            editing_out,
  output logic                            param_mode_out,
  output logic                            sample_out,
  output logic                            evaluate_out,
  output logic [IO_WIDTH-1:0]             input_image_out,
  output logic [IO_WIDTH-1:0]             outputs_out,
  output logic [RETAIN_WIDTH-1:0]         retain_out,
  output logic                            retain_save_out,
  output plc_state_pkg::led_colour_t      status_led_out,
  output plc_state_pkg::led_colour_t      link_led_out
);

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_COPY,
    ST_DECIDE,
    ST_NOPROG,
    ST_STOP,
    ST_RUN
  } ctrl_state_t;

  ctrl_state_t                              state;
  logic [plc_state_pkg::COPY_CNT_WIDTH-1:0] copy_count;
  logic                                     prog_present;
  logic                                     run_now;
  logic                                     card_has_prog;

  scan_if scan ();

  assign card_has_prog = card_present_in && card_prog_valid_in;
  assign run_now       = (state == ST_RUN);
  assign scan.run      = run_now;
  assign scan.inputs   = inputs_in;
  assign scan.result   = result_in;

  // ---------------------------------------------------------------------------
  // Startup and operating state
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state        <= ST_BOOT;
      prog_present <= 1'b0;
      copy_count   <= '0;
    end else begin
      unique case (state)
        ST_BOOT: begin
          if (card_has_prog) begin
            state <= ST_COPY;
          end else if (saved_editing_in) begin
            prog_present <= 1'b0;
            state        <= ST_DECIDE;
          end else begin
            prog_present <= internal_prog_valid_in;
            state        <= ST_DECIDE;
          end
          copy_count <= '0;
        end
        ST_COPY: begin
          if (copy_count ==
              plc_state_pkg::COPY_CNT_WIDTH'(plc_state_pkg::COPY_CYCLES - 1)) begin
            prog_present <= 1'b1;
            state        <= ST_DECIDE;
          end
          copy_count <= copy_count + 1'b1;
        end
        ST_DECIDE: begin
          if (!prog_present) begin
            state <= ST_NOPROG;
          end else if (!has_display_in || saved_run_in) begin
            state <= ST_RUN;
          end else begin
            state <= ST_STOP;
          end
        end
        ST_NOPROG: begin
          if (has_display_in && esc_in) begin
            state <= ST_STOP;
          end else if (!has_display_in && internal_prog_valid_in) begin
            prog_present <= 1'b1;
            state        <= ST_RUN;
          end
        end
        ST_STOP: begin
          if (!has_display_in && prog_present) begin
            state <= ST_RUN;
          end else if (start_req_in && prog_present && !editing_out) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop_req_in && !param_mode_out) begin
            state <= ST_STOP;
          end
        end
      endcase
      if (power_fail_in && editing_out) begin
        prog_present <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Card transfer and program clear strobes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      copy_card_out <= 1'b0;
    end else begin
      copy_card_out <= (state == ST_COPY);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clear_prog_out <= 1'b0;
    end else begin
      clear_prog_out <= (state == ST_BOOT && !card_has_prog && saved_editing_in)
                        || (power_fail_in && editing_out);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      card_write_out <= 1'b0;
    end else begin
      card_write_out <= card_write_req_in && has_display_in && card_present_in
                        && (state == ST_STOP);
    end
  end

  // ---------------------------------------------------------------------------
  // Editing and parameter modes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      editing_out <= 1'b0;
    end else begin
      if (!editing_out && edit_req_in && has_display_in
          && (state == ST_STOP || state == ST_NOPROG)) begin
        editing_out <= 1'b1;
      end else if (edit_exit_in) begin
        editing_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      param_mode_out <= 1'b0;
    end else begin
      if (!param_mode_out && param_req_in && has_display_in && state == ST_RUN) begin
        param_mode_out <= 1'b1;
      end else if (param_exit_in || state != ST_RUN) begin
        param_mode_out <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Status indication
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      no_prog_msg_out <= 1'b0;
    end else begin
      no_prog_msg_out <= has_display_in && (state == ST_NOPROG);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      running_out <= 1'b0;
    end else begin
      running_out <= run_now;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_led_out <= plc_state_pkg::LED_OFF;
    end else begin
      if (has_display_in) begin
        status_led_out <= plc_state_pkg::LED_OFF;
      end else if (run_now) begin
        status_led_out <= plc_state_pkg::LED_GREEN;
      end else begin
        status_led_out <= plc_state_pkg::LED_RED;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Scan cycle gating
  // ---------------------------------------------------------------------------
  scan_engine u_scan (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .scan   (scan)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sample_out   <= 1'b0;
      evaluate_out <= 1'b0;
    end else begin
      sample_out   <= run_now && scan.sample;
      evaluate_out <= run_now && scan.evaluate;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      input_image_out <= '0;
    end else begin
      if (run_now && scan.sample) begin
        input_image_out <= inputs_in;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      outputs_out <= '0;
    end else begin
      outputs_out <= run_now ? scan.outputs : '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Retentive values
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      retain_out <= '0;
    end else begin
      if (state == ST_DECIDE) begin
        retain_out <= retain_enable_in ? saved_retain_in : '0;
      end else if (run_now && scan.drive) begin
        retain_out <= live_retain_in;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      retain_save_out <= 1'b0;
    end else begin
      retain_save_out <= power_fail_in && retain_enable_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Expansion link indicator
  // ---------------------------------------------------------------------------
  expansion_led u_link_led (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .link_ok_in (link_ok_in),
    .colour_out (link_led_out)
  );

endmodule : controller_run_stop_state

`default_nettype wire

/* verif/run_stop_sva.sv */
// Checker for the run/stop state block.
// Assumes one clock domain and an active-high reset.
`default_nettype none

module run_stop_sva #(
  parameter int IO_WIDTH = 8
) (
  input wire logic                       clk_in,
  input wire logic                       rst_in,
  input wire logic                       has_display_in,
  input wire logic                       card_prog_valid_in,
  input wire logic                       link_ok_in,
  input wire logic                       card_write_out,
  input wire logic                       no_prog_msg_out,
  input wire logic                       running_out,
  input wire logic                       editing_out,
  input wire logic                       param_mode_out,
  input wire logic                       sample_out,
  input wire logic                       evaluate_out,
  input wire logic                       copy_card_out,
  input wire logic [IO_WIDTH-1:0]        outputs_out,
  input wire plc_state_pkg::led_colour_t link_led_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  AST_NO_PROG_MSG: assert property (no_prog_msg_out |-> has_display_in)
    else $error("prompt on a displayless unit");
  AST_COPY: assert property ($rose(copy_card_out) |-> $past(card_prog_valid_in))
    else $error("copy without a card program");
  AST_STOP_OUT: assert property (!running_out [*3] |-> outputs_out == '0)
    else $error("outputs on in stop");
  AST_SAMPLE: assert property (sample_out |-> running_out || $past(running_out))
    else $error("sample outside run");
  AST_EVAL: assert property (evaluate_out |-> $past(sample_out))
    else $error("evaluate not after sample");
  AST_EDIT: assert property ($rose(editing_out) |-> !running_out)
    else $error("edit entered from run");
  AST_PARAM: assert property ($rose(param_mode_out) |-> running_out)
    else $error("param mode entered from stop");
  AST_GREEN: assert property ((link_ok_in [*3] ##0 link_led_out != plc_state_pkg::LED_ORANGE)
    |-> link_led_out == plc_state_pkg::LED_GREEN)
    else $error("link up but not green");
  AST_RED: assert property ((!link_ok_in [*3] ##0 link_led_out != plc_state_pkg::LED_ORANGE)
    |-> link_led_out == plc_state_pkg::LED_RED)
    else $error("link down but not red");
  AST_INIT: assert property ($fell(rst_in) |-> (link_led_out == plc_state_pkg::LED_ORANGE) [*8])
    else $error("no orange after reset");
  AST_CARD_WR: assert property (!has_display_in |-> !card_write_out)
    else $error("card write without display");

  cover property (running_out && sample_out);
  cover property (editing_out);
  cover property (copy_card_out);
  cover property (link_led_out == plc_state_pkg::LED_GREEN);
endmodule : run_stop_sva

bind controller_run_stop_state run_stop_sva #(.IO_WIDTH(IO_WIDTH)) u_sva (
  .clk_in, .rst_in, .has_display_in, .card_prog_valid_in, .link_ok_in, .card_write_out,
  .no_prog_msg_out, .running_out, .editing_out, .param_mode_out, .sample_out,
  .evaluate_out, .copy_card_out, .outputs_out, .link_led_out
);

`default_nettype wire

/* verif/card_link_model.sv */
// Model of the program card slot and the left-hand expansion neighbour.
// Assumes the bench drives its controls away from the rising edge.
`default_nettype none

module card_link_model (
  input  wire logic clk_in,
  input  wire logic inserted_in,
  input  wire logic loaded_in,
  input  wire logic link_up_in,
  output logic      card_present_out,
  output logic      card_prog_valid_out,
  output logic      link_ok_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic link_q = 1'b0;

  // An empty slot reads as no program, like a pulled-down line.
  assign card_present_out    = inserted_in;
  assign card_prog_valid_out = inserted_in & loaded_in;

  // The neighbour answers one cycle after it comes up.
  always @(posedge clk_in) begin
    link_q <= link_up_in;
  end
  assign link_ok_out = link_q;
endmodule : card_link_model

`default_nettype wire

/* verif/controller_run_stop_state_tb_top.sv */
// Self-checking bench for the run/stop state block.
// Assumes the card and neighbour model beside it.
`default_nettype none

module controller_run_stop_state_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, rst_in = 1, has_display_in = 1, internal_prog_valid_in = 0;
  logic card_present_in, card_prog_valid_in, saved_run_in = 0, saved_editing_in = 0;
  logic retain_enable_in = 0, power_fail_in = 0, esc_in = 0, start_req_in = 0;
  logic stop_req_in = 0, edit_req_in = 0, edit_exit_in = 0, param_req_in = 0;
  logic param_exit_in = 0, card_write_req_in = 0, link_ok_in, ins = 0, loaded = 0, link_up = 0;
  logic [15:0] saved_retain_in = 16'h0000, live_retain_in = 16'h0000, retain_out;
  logic [7:0] inputs_in = 8'h00, result_in = 8'h00, input_image_out, outputs_out;
  logic copy_card_out, clear_prog_out, card_write_out, no_prog_msg_out, running_out;
  logic editing_out, param_mode_out, sample_out, evaluate_out, retain_save_out;
  plc_state_pkg::led_colour_t status_led_out, link_led_out;
  int miscompares = 0;
  int cmp_count = 0;

  controller_run_stop_state dut (
    .clk_in, .rst_in, .has_display_in, .internal_prog_valid_in, .card_present_in,
    .card_prog_valid_in, .saved_run_in, .saved_editing_in, .retain_enable_in,
    .saved_retain_in, .live_retain_in, .power_fail_in, .esc_in, .start_req_in,
    .stop_req_in, .edit_req_in, .edit_exit_in, .param_req_in, .param_exit_in,
    .card_write_req_in, .inputs_in, .result_in, .link_ok_in, .copy_card_out,
    .clear_prog_out, .card_write_out, .no_prog_msg_out, .running_out, .editing_out,
    .param_mode_out, .sample_out, .evaluate_out, .input_image_out, .outputs_out,
    .retain_out, .retain_save_out, .status_led_out, .link_led_out
  );

  card_link_model partner (
    .clk_in, .inserted_in(ins), .loaded_in(loaded), .link_up_in(link_up),
    .card_present_out(card_present_in), .card_prog_valid_out(card_prog_valid_in),
    .link_ok_out(link_ok_in)
  );

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic wrap_up();
    $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_hi(ref logic sig, input int lim);
    int i;
    for (i = 0; i < lim && sig !== 1'b1; i++) begin
      @(negedge clk_in);
    end
    if (sig !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
  endtask : wait_hi

  task automatic pulse(ref logic sig);
    @(negedge clk_in);
    sig = 1'b1;
    @(negedge clk_in);
    sig = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask : pulse

  task automatic boot(input logic disp, iprog, card, srun);
    @(negedge clk_in);
    rst_in = 1'b1;
    has_display_in = disp;
    internal_prog_valid_in = iprog;
    ins = card;
    loaded = card;
    saved_run_in = srun;
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
  endtask : boot

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic sc_no_prog();
    boot(1'b1, 1'b0, 1'b0, 1'b1);
    inputs_in = 8'hA5;
    pulse(start_req_in);
    repeat (10) @(negedge clk_in);
    chk(no_prog_msg_out, 1'b1);
    chk(running_out, 1'b0);
    chk(input_image_out, 8'h00);
    chk(outputs_out, 8'h00);
    pulse(esc_in);
  endtask : sc_no_prog

  task automatic sc_card_run();
    boot(1'b1, 1'b0, 1'b1, 1'b1);
    wait_hi(copy_card_out, 10);
    chk(copy_card_out, 1'b1);
    wait_hi(running_out, 60);
    inputs_in = 8'h3C;
    result_in = 8'hC3;
    repeat (12) @(negedge clk_in);
    chk(input_image_out, 8'h3C);
    chk(outputs_out, 8'hC3);
    pulse(edit_req_in);
    chk(editing_out, 1'b0);
    pulse(param_req_in);
    chk(param_mode_out, 1'b1);
    pulse(param_exit_in);
    pulse(stop_req_in);
    chk(running_out, 1'b0);
    chk(outputs_out, 8'h00);
    inputs_in = 8'h99;
    repeat (8) @(negedge clk_in);
    chk(input_image_out, 8'h3C);
    pulse(param_req_in);
    chk(param_mode_out, 1'b0);
    pulse(edit_req_in);
    chk(editing_out, 1'b1);
    power_fail_in = 1'b1;
    @(negedge clk_in);
    chk(clear_prog_out, 1'b1);
    power_fail_in = 1'b0;
    pulse(edit_exit_in);
  endtask : sc_card_run

  task automatic sc_resume_stop();
    retain_enable_in = 1'b1;
    saved_retain_in = 16'h5A3C;
    boot(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (40) @(negedge clk_in);
    chk(running_out, 1'b0);
    chk(retain_out, 16'h5A3C);
    live_retain_in = 16'h1234;
    power_fail_in = 1'b1;
    wait_hi(retain_save_out, 10);
    chk(retain_save_out, 1'b1);
    power_fail_in = 1'b0;
    retain_enable_in = 1'b0;
  endtask : sc_resume_stop

  task automatic sc_displayless();
    boot(1'b0, 1'b1, 1'b1, 1'b0);
    repeat (2) @(negedge clk_in);
    chk(status_led_out, plc_state_pkg::LED_RED);
    wait_hi(running_out, 60);
    repeat (3) @(negedge clk_in);
    chk(status_led_out, plc_state_pkg::LED_GREEN);
    card_write_req_in = 1'b1;
    repeat (5) @(negedge clk_in);
    chk(card_write_out, 1'b0);
    card_write_req_in = 1'b0;
  endtask : sc_displayless

  task automatic sc_saved_edit();
    saved_editing_in = 1'b1;
    boot(1'b1, 1'b1, 1'b0, 1'b1);
    wait_hi(clear_prog_out, 20);
    chk(clear_prog_out, 1'b1);
    repeat (4) @(negedge clk_in);
    chk(no_prog_msg_out, 1'b1);
    chk(running_out, 1'b0);
    saved_editing_in = 1'b0;
  endtask : sc_saved_edit

  task automatic sc_link();
    link_up = 1'b1;
    boot(1'b1, 1'b1, 1'b0, 1'b0);
    repeat (5) @(negedge clk_in);
    chk(link_led_out, plc_state_pkg::LED_ORANGE);
    repeat (110) @(negedge clk_in);
    chk(link_led_out, plc_state_pkg::LED_GREEN);
    link_up = 1'b0;
    repeat (5) @(negedge clk_in);
    chk(link_led_out, plc_state_pkg::LED_RED);
  endtask : sc_link

  initial begin
    #500us;
    miscompares++;
    wrap_up();
  end

  initial begin
    sc_no_prog();
    sc_card_run();
    sc_resume_stop();
    sc_displayless();
    sc_saved_edit();
    sc_link();
    wrap_up();
  end
endmodule : controller_run_stop_state_tb_top

`default_nettype wire
